// ### ccs_regs.svh
// register offsets, field positions and codes of the channel supervisor
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
`define CCS_ADDR_CTRL      4'h0
`define CCS_ADDR_CMD_SEL   4'h1
`define CCS_ADDR_REF_SEL   4'h2
`define CCS_ADDR_OPS_SEL   4'h3
`define CCS_ADDR_PID_SEL   4'h4
`define CCS_ADDR_FLAGS     4'h5
`define CCS_ADDR_IRQ_STAT  4'h6
`define CCS_ADDR_IRQ_MASK  4'h7
`define CCS_ADDR_SPEED_W   4'h8
`define CCS_ADDR_FREQ_W    4'h9
`define CCS_ADDR_PID_SP_W  4'hA
`define CCS_ADDR_PID_FB_W  4'hB
`define CCS_ADDR_COEFF_W   4'hC
`define CCS_ADDR_REACTION  4'hD
`define CCS_ADDR_DRIVE     4'hE
`define CCS_SRC_NONE       2'h0
`define CCS_SRC_BUS        2'h1
`define CCS_SRC_CAN        2'h2
`define CCS_SRC_CARD       2'h3
`define CCS_IRQ_NET_FAULT  0
`define CCS_IRQ_DRV_FAULT  1
`define CCS_IRQ_SW_FAULT   2
`define CCS_IRQ_COMM_LOSS  3
`define CCS_IRQ_WIDTH      4
`define CCS_UNMAPPED_DATA  32'hDEADBEEF
`endif

// ### ccs_pkg.sv
// types of the channel supervisor
package ccs_pkg;
    typedef enum logic [2:0] {
        CCS_REACT_FAULT,
        CCS_REACT_STOP,
        CCS_REACT_IGNORE,
        CCS_REACT_HOLD,
        CCS_REACT_FALLBACK
    } ccs_react_t;
    typedef enum logic [1:0] {
        CCS_BUS_IDLE,
        CCS_BUS_ANSWER
    } ccs_bus_t;
endpackage

// ### ccs_word_mem.sv
// small word store with registered read port for the per-channel reference words
`timescale 1ns/1ps
module ccs_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    // storage holds no reset; pid_feedback loads the read word whether or not the channel's seen flag is set
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule

// ### ccs_supervisor.sv
// communication channel supervisor: channel flags, faults, start gating and register bus
`timescale 1ns/1ps
// Operation
// - problem on connected participant channel raises network fault with configured reaction
// - problem on disconnected or non participant channel raises no fault
// - any problem clears the channel's connected flag
// - fixed-function command bits on inactive channel do not make it participant
// - channel enabled only after its needed command word and any one reference word arrived once
// - start refused unless every participant channel is enabled
// - operation enabled blocked until the network reference written once
// - any problem clears the channel's enabled flag
// - switching from enabled to disabled channel raises network fault at once
// - card management fault raises drive fault regardless of channel state
// - summing input on a channel with operations active makes it participant
// - switch bit on a card allows start only once that card is enabled
// - PID feedback taken from the bus analog input of the selected channel
// - network fault applies one of five configured reactions
// - first command or reference write makes a channel connected
// - channel carrying a needed command or reference is participant
module ccs_supervisor
    import ccs_pkg::*;
#(
    parameter int NCH = 3
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [2:0]  ch_cmd_wr,
    input  wire logic [2:0]  ch_comm_problem,
    input  wire logic        card_mgmt_fault,
    output logic             net_fault,
    output logic             drive_fault,
    output logic [2:0]       fault_reaction,
    output logic             start_allowed,
    output logic             op_enable_allowed,
    output logic [15:0]      pid_feedback,
    output logic             irq
);
`include "ccs_regs.svh"
    // control registers written by software
    logic [1:0]  cmd_sel_reg, cmd_sel_next;
    logic [7:0]  ref_sel_reg, ref_sel_next;     // [1:0] ref1 [3:2] ref1b [5:4] ref2 [7:6] switch card
    logic [15:0] ops_sel_reg, ops_sel_next;     // sum2 sum3 sub2 sub3 mult2 mult3 | [12] ops on
    logic [3:0]  pid_sel_reg, pid_sel_next;     // [1:0] ai channel [2] feedback from bus ai
    logic [2:0]  react_reg, react_next;
    logic [NCH-1:0] conn_reg, conn_next, part_reg, enab_reg, enab_next;
    logic [NCH-1:0] cmd_seen_reg, cmd_seen_next, ref_seen_reg, ref_seen_next;
    logic [NCH-1:0] prob_conn_part, need_ref, need_cmd;
    logic [3:0]  stat_reg, stat_next, mask_reg, mask_next;
    logic [1:0]  act_reg;
    logic        net_fault_reg, net_fault_next, drv_fault_reg, drv_fault_next;
    logic        start_reg, opena_reg, irq_reg;
    logic [31:0] rdata_reg, rdata_next;
    ccs_bus_t    bus_reg, bus_next;
    logic        wait_reg;
    logic [15:0] mem_rd;
    logic        ref_wr, wr_hit;
    logic [1:0]  wr_ch;
    logic        sw_fault;
    logic [3:0]  ev;

    // words written by the master land in the store; ch index rides in data[17:16]
    // a write commits only at the edge that sees waitrequest low, as the bus defines it
    assign wr_hit = avs_write && (bus_reg == CCS_BUS_ANSWER);
    assign wr_ch  = avs_writedata[17:16];
    assign ref_wr = wr_hit && (avs_address >= `CCS_ADDR_SPEED_W)
                    && (avs_address <= `CCS_ADDR_COEFF_W);

    // one slot per word kind and channel code, so no two words share a slot
    ccs_word_mem #(.WIDTH(16), .DEPTH(32), .AW(5)) u_mem (
        .sys_clk (sys_clk),
        .wr_en   (ref_wr),
        .wr_addr ({avs_address[2:0], wr_ch}),
        .wr_data (avs_writedata[15:0]),
        .rd_addr ({3'h3, pid_sel_reg[1:0]}),   // bus analog input word kind
        .rd_data (mem_rd)
    );

    // per channel: what it must deliver, and how its flags move
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_ch
            localparam logic [1:0] ID = 2'(c + 1);
            // channel carrying active command or reference
            // only the active command channel and the switch card count, fixed bits elsewhere ignored
            assign need_cmd[c] = (cmd_sel_reg == ID) || (ref_sel_reg[7:6] == ID);
            // summing or other operation input counts when operations active
            // bus analog input channel counts for PID feedback
            assign need_ref[c] = (ref_sel_reg[1:0] == ID) || (ref_sel_reg[3:2] == ID)
                || (ref_sel_reg[5:4] == ID)
                || (ops_sel_reg[12] && ((ops_sel_reg[1:0] == ID) || (ops_sel_reg[3:2] == ID)
                || (ops_sel_reg[5:4] == ID) || (ops_sel_reg[7:6] == ID)
                || (ops_sel_reg[9:8] == ID) || (ops_sel_reg[11:10] == ID)))
                || (pid_sel_reg[2] && (pid_sel_reg[1:0] == ID));
            always_comb begin
                part_reg[c] = need_cmd[c] || need_ref[c];
            end
            assign prob_conn_part[c] = ch_comm_problem[c] && conn_reg[c] && part_reg[c];
            always_comb begin
                conn_next[c]     = conn_reg[c];
                cmd_seen_next[c] = cmd_seen_reg[c];
                ref_seen_next[c] = ref_seen_reg[c];
                // first command or reference write connects
                if (ch_cmd_wr[c]) begin
                    conn_next[c]     = 1'b1;
                    cmd_seen_next[c] = 1'b1;
                end
                if (ref_wr && (wr_ch == ID)) begin
                    conn_next[c]     = 1'b1;
                    ref_seen_next[c] = 1'b1;
                end
                // problem disconnects; loss wins so a dead link stays down
                // problem also forgets received words so enable drops
                if (ch_comm_problem[c]) begin
                    conn_next[c]     = 1'b0;
                    cmd_seen_next[c] = 1'b0;
                    ref_seen_next[c] = 1'b0;
                end
                // enabled once the needed command word and any one reference word were seen
                enab_next[c] = conn_next[c] && (cmd_seen_next[c] || !need_cmd[c])
                               && (ref_seen_next[c] || !need_ref[c]);
            end
        end
    endgenerate

    // active reference switch landing on a disabled channel
    // only a move away from an enabled channel counts, so first configuration stays quiet
    assign sw_fault = (ref_sel_reg[1:0] != act_reg) && (ref_sel_reg[1:0] != `CCS_SRC_NONE)
                      && (act_reg != `CCS_SRC_NONE) && enab_reg[act_reg-2'h1]
                      && !enab_reg[ref_sel_reg[1:0]-2'h1];

    // faults and sticky status; hardware set wins over software clear
    always_comb begin
        ev = 4'h0;
        // only connected participant problems count here
        ev[`CCS_IRQ_NET_FAULT] = (|prob_conn_part) || sw_fault;
        // management fault is independent of channel state
        ev[`CCS_IRQ_DRV_FAULT] = card_mgmt_fault
            || (ev[`CCS_IRQ_NET_FAULT] && (react_reg == 3'(CCS_REACT_FAULT)));
        ev[`CCS_IRQ_SW_FAULT]  = sw_fault;
        ev[`CCS_IRQ_COMM_LOSS] = |ch_comm_problem;
        net_fault_next = net_fault_reg || ev[`CCS_IRQ_NET_FAULT];
        drv_fault_next = drv_fault_reg || ev[`CCS_IRQ_DRV_FAULT];
        stat_next = stat_reg;
        if (wr_hit && (avs_address == `CCS_ADDR_IRQ_STAT)) begin
            stat_next = stat_reg & ~avs_writedata[3:0];
        end
        if (wr_hit && (avs_address == `CCS_ADDR_DRIVE) && avs_writedata[0]) begin
            net_fault_next = 1'b0;
            drv_fault_next = 1'b0;
        end
        stat_next = stat_next | ev;
        net_fault_next = net_fault_next || ev[`CCS_IRQ_NET_FAULT];
        drv_fault_next = drv_fault_next || ev[`CCS_IRQ_DRV_FAULT];
    end

    // register writes and read mux; one wait cycle, answer on the following edge
    always_comb begin
        cmd_sel_next = cmd_sel_reg;
        ref_sel_next = ref_sel_reg;
        ops_sel_next = ops_sel_reg;
        pid_sel_next = pid_sel_reg;
        react_next   = react_reg;
        mask_next    = mask_reg;
        rdata_next   = rdata_reg;
        bus_next     = CCS_BUS_IDLE;
        if ((avs_read || avs_write) && bus_reg == CCS_BUS_IDLE) begin
            bus_next = CCS_BUS_ANSWER;
        end
        if (wr_hit) begin
            case (avs_address)
                `CCS_ADDR_CMD_SEL:  cmd_sel_next = avs_writedata[1:0];
                `CCS_ADDR_REF_SEL:  ref_sel_next = avs_writedata[7:0];
                `CCS_ADDR_OPS_SEL:  ops_sel_next = avs_writedata[15:0];
                `CCS_ADDR_PID_SEL:  pid_sel_next = avs_writedata[3:0];
                `CCS_ADDR_IRQ_MASK: mask_next    = avs_writedata[3:0];
                `CCS_ADDR_REACTION: begin
                    // five reactions; others fall back to drive fault
                    react_next = (avs_writedata[2:0] > 3'(CCS_REACT_FALLBACK))
                                 ? 3'(CCS_REACT_FAULT) : avs_writedata[2:0];
                end
                default: ;
            endcase
        end
        if (avs_read && bus_reg == CCS_BUS_IDLE) begin
            case (avs_address)
                `CCS_ADDR_CMD_SEL:  rdata_next = {30'h0, cmd_sel_reg};
                `CCS_ADDR_REF_SEL:  rdata_next = {24'h0, ref_sel_reg};
                `CCS_ADDR_OPS_SEL:  rdata_next = {16'h0, ops_sel_reg};
                `CCS_ADDR_PID_SEL:  rdata_next = {28'h0, pid_sel_reg};
                `CCS_ADDR_FLAGS:    rdata_next = {13'h0, enab_reg, 5'h0, part_reg,
                                                  5'h0, conn_reg};
                `CCS_ADDR_IRQ_STAT: rdata_next = {28'h0, stat_reg};
                `CCS_ADDR_IRQ_MASK: rdata_next = {28'h0, mask_reg};
                `CCS_ADDR_REACTION: rdata_next = {29'h0, react_reg};
                `CCS_ADDR_DRIVE:    rdata_next = {28'h0, opena_reg, start_reg,
                                                  drv_fault_reg, net_fault_reg};
                default:            rdata_next = `CCS_UNMAPPED_DATA;
            endcase
        end
    end

    // all flags and control registers cleared on reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conn_reg <= '0; enab_reg <= '0; cmd_seen_reg <= '0; ref_seen_reg <= '0;
            cmd_sel_reg <= 2'h0; ref_sel_reg <= 8'h00; ops_sel_reg <= 16'h0000;
            pid_sel_reg <= 4'h0; react_reg <= 3'h0; stat_reg <= 4'h0; mask_reg <= 4'h0;
            act_reg <= 2'h0; net_fault_reg <= 1'b0; drv_fault_reg <= 1'b0;
            start_reg <= 1'b0; opena_reg <= 1'b0; irq_reg <= 1'b0;
            rdata_reg <= 32'h0; bus_reg <= CCS_BUS_IDLE; pid_feedback <= 16'h0000;
            wait_reg <= 1'b1;
        end else begin
            conn_reg <= conn_next; enab_reg <= enab_next;
            cmd_seen_reg <= cmd_seen_next; ref_seen_reg <= ref_seen_next;
            cmd_sel_reg <= cmd_sel_next; ref_sel_reg <= ref_sel_next;
            ops_sel_reg <= ops_sel_next; pid_sel_reg <= pid_sel_next;
            react_reg <= react_next; stat_reg <= stat_next; mask_reg <= mask_next;
            act_reg <= ref_sel_reg[1:0];
            net_fault_reg <= net_fault_next; drv_fault_reg <= drv_fault_next;
            // start only if every participant channel is enabled
            // switch card enabled is part of the same check
            start_reg <= ((part_reg & ~enab_reg) == '0) && !drv_fault_reg;
            // operation enable waits for the reference to arrive once
            opena_reg <= ((part_reg & ~enab_reg) == '0) && !drv_fault_reg
                         && (ref_sel_reg[1:0] == `CCS_SRC_NONE
                             || ref_seen_reg[ref_sel_reg[1:0]-2'h1]);
            irq_reg <= |(stat_reg & mask_reg);
            rdata_reg <= rdata_next; bus_reg <= bus_next;
            // waitrequest kept in its own flop so the pin carries no decode glitch
            wait_reg <= (bus_next == CCS_BUS_IDLE);
            // feedback from bus analog input word of selected channel
            if (pid_sel_reg[2]) begin
                pid_feedback <= mem_rd;
            end
        end
    end

    assign avs_readdata      = rdata_reg;
    assign avs_waitrequest   = wait_reg;
    assign net_fault         = net_fault_reg;
    assign drive_fault       = drv_fault_reg;
    assign fault_reaction    = react_reg;
    assign start_allowed     = start_reg;
    assign op_enable_allowed = opena_reg;
    assign irq               = irq_reg;

    // checks next to the logic
    a_prob_disconnects: assert property (@(posedge sys_clk) disable iff (rst)
        ch_comm_problem[0] |=> !conn_reg[0] && !enab_reg[0])
        else $error("channel stayed connected after problem");
    a_net_fault_set: assert property (@(posedge sys_clk) disable iff (rst)
        prob_conn_part[0] |=> net_fault_reg)
        else $error("network fault missed");
    a_mgmt_drive: assert property (@(posedge sys_clk) disable iff (rst)
        card_mgmt_fault |=> drv_fault_reg)
        else $error("management fault missed");
    a_start_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (part_reg[0] && !enab_reg[0]) |=> !start_reg)
        else $error("start allowed with disabled channel");
    a_first_write: assert property (@(posedge sys_clk) disable iff (rst)
        (ch_cmd_wr[1] && !ch_comm_problem[1]) |=> conn_reg[1])
        else $error("channel not connected after write");
    a_enab_needs: assert property (@(posedge sys_clk) disable iff (rst)
        enab_reg[0] |-> conn_reg[0])
        else $error("enabled without connection");
    a_quiet_problem: assert property (@(posedge sys_clk) disable iff (rst)
        (ch_comm_problem != 0 && prob_conn_part == 0 && !sw_fault && !net_fault_reg)
        |=> !net_fault_reg)
        else $error("spurious network fault");
    a_switch_fault: assert property (@(posedge sys_clk) disable iff (rst)
        sw_fault |=> net_fault_reg)
        else $error("switch fault missed");
    c_fault_seen: cover property (@(posedge sys_clk) disable iff (rst) $rose(net_fault_reg));
    c_start_ok: cover property (@(posedge sys_clk) disable iff (rst) $rose(start_reg));
    c_op_enable: cover property (@(posedge sys_clk) disable iff (rst) $rose(opena_reg));
endmodule

// ### ccs_plc_model.sv
// fieldbus master model: register requests and per-channel word events
`timescale 1ns/1ps
module ccs_plc_model (
    input  wire logic        sys_clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [3:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [2:0]  ch_cmd_wr,
    output logic      [2:0]  ch_comm_problem,
    output logic             card_mgmt_fault
);
    // idle bus and quiet channels from time zero
    initial begin
        avs_address     = 4'h0;
        avs_read        = 1'h0;
        avs_write       = 1'h0;
        avs_writedata   = 32'h0000_0000;
        ch_cmd_wr       = 3'h0;
        ch_comm_problem = 3'h0;
        card_mgmt_fault = 1'h0;
    end
    // request held until waitrequest is sampled low, released only after that edge
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'h0) begin
            @(posedge sys_clk);
        end
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
    endtask
    // each word on its function's channel
    task automatic send_word(input logic [3:0] a, input logic [1:0] ch, input logic [15:0] w);
        logic [31:0] q;
        xfer(1'h1, a, {14'h0000, ch, w}, q);
    endtask
    // one-cycle event: command word arrival or channel problem
    task automatic pulse(input logic prob, input logic [2:0] m);
        @(posedge sys_clk);
        if (prob) begin
            ch_comm_problem <= m;
        end else begin
            ch_cmd_wr <= m;
        end
        @(posedge sys_clk);
        ch_comm_problem <= 3'h0;
        ch_cmd_wr       <= 3'h0;
    endtask
    // card management fault is a level, not a pulse
    task automatic set_mgmt(input logic v);
        @(posedge sys_clk);
        card_mgmt_fault <= v;
    endtask
endmodule

// ### tb_top.sv
// self-checking bench of the channel supervisor
`timescale 1ns/1ps
`include "ccs_regs.svh"
`define CHK(nm, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("unexpected %s expected %0h seen %0h", nm, (exp), (got)); \
    end \
end
module tb_top;
    logic        sys_clk;
    logic        rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  ch_cmd_wr;
    logic [2:0]  ch_comm_problem;
    logic        card_mgmt_fault;
    logic        net_fault;
    logic        drive_fault;
    logic [2:0]  fault_reaction;
    logic        start_allowed;
    logic        op_enable_allowed;
    logic [15:0] pid_feedback;
    logic        irq;
    logic [31:0] f;
    logic        irq_a;
    int          n_fail;
    int          samples_checked;
    int          cycles;

    ccs_supervisor i_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .ch_cmd_wr, .ch_comm_problem, .card_mgmt_fault,
        .net_fault, .drive_fault, .fault_reaction, .start_allowed, .op_enable_allowed,
        .pid_feedback, .irq);
    ccs_plc_model i_plc (.sys_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .ch_cmd_wr, .ch_comm_problem, .card_mgmt_fault);

    // 100 MHz clock
    initial sys_clk = 1'h0;
    always #5 sys_clk = ~sys_clk;

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_plc.xfer(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a);
        i_plc.xfer(1'h0, a, 32'h0000_0000, f);
    endtask
    // registered outputs lag the bus edge; a few cycles covers every stage
    task automatic settle();
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            results();
        end
    end

    task automatic t_reset();
        `CHK("waitrequest", 1'h1, avs_waitrequest);
        `CHK("net_fault", 1'h0, net_fault);
        rd(`CCS_ADDR_FLAGS);
        `CHK("flags", 32'h0000_0000, f);
        rd(4'hF);
        `CHK("unmapped", `CCS_UNMAPPED_DATA, f);
    endtask
    task automatic t_enable();
        wr(`CCS_ADDR_CMD_SEL, {30'h0, `CCS_SRC_BUS});
        wr(`CCS_ADDR_REF_SEL, {30'h0, `CCS_SRC_BUS});
        i_plc.pulse(1'h0, 3'h1);
        settle();
        rd(`CCS_ADDR_FLAGS);
        `CHK("conn0", 1'h1, f[0]);
        `CHK("part0", 1'h1, f[8]);
        `CHK("enab0 early", 1'h0, f[16]);
        `CHK("start early", 1'h0, start_allowed);
        `CHK("op early", 1'h0, op_enable_allowed);
        i_plc.send_word(`CCS_ADDR_SPEED_W, `CCS_SRC_BUS, 16'h05DC);
        settle();
        rd(`CCS_ADDR_FLAGS);
        `CHK("enab0", 1'h1, f[16]);
        `CHK("start", 1'h1, start_allowed);
        `CHK("op", 1'h1, op_enable_allowed);
    endtask
    // every reaction code on a participant loss
    task automatic t_react();
        for (int r = 0; r < 5; r++) begin
            wr(`CCS_ADDR_REACTION, 32'(r));
            wr(`CCS_ADDR_DRIVE, 32'h0000_0001);
            i_plc.pulse(1'h0, 3'h1);
            i_plc.pulse(1'h1, 3'h1);
            settle();
            `CHK("net_fault", 1'h1, net_fault);
            `CHK("reaction", 3'(r), fault_reaction);
            `CHK("drive_fault", (r == 0), drive_fault);
            rd(`CCS_ADDR_FLAGS);
            `CHK("conn0 lost", 1'h0, f[0]);
            `CHK("enab0 lost", 1'h0, f[16]);
        end
    endtask
    task automatic t_nonpart();
        wr(`CCS_ADDR_DRIVE, 32'h0000_0001);
        i_plc.pulse(1'h0, 3'h2);
        settle();
        rd(`CCS_ADDR_FLAGS);
        `CHK("conn1", 1'h1, f[1]);
        `CHK("part1", 1'h0, f[9]);
        i_plc.pulse(1'h1, 3'h2);
        settle();
        `CHK("net_fault", 1'h0, net_fault);
        `CHK("drive_fault", 1'h0, drive_fault);
        rd(`CCS_ADDR_FLAGS);
        `CHK("conn1 lost", 1'h0, f[1]);
    endtask
    task automatic t_switch();
        wr(`CCS_ADDR_DRIVE, 32'h0000_0001);
        i_plc.pulse(1'h0, 3'h1);
        i_plc.send_word(`CCS_ADDR_SPEED_W, `CCS_SRC_BUS, 16'h0100);
        settle();
        `CHK("no fault", 1'h0, net_fault);
        wr(`CCS_ADDR_REF_SEL, {30'h0, `CCS_SRC_CAN});
        settle();
        `CHK("switch fault", 1'h1, net_fault);
        wr(`CCS_ADDR_DRIVE, 32'h0000_0001);
        wr(`CCS_ADDR_REF_SEL, {30'h0, `CCS_SRC_BUS});
        settle();
        `CHK("no fault from disabled", 1'h0, net_fault);
    endtask
    // switch bit on the card blocks start until the card is enabled
    task automatic t_card();
        wr(`CCS_ADDR_REF_SEL, {24'h0, `CCS_SRC_CARD, 4'h0, `CCS_SRC_BUS});
        settle();
        `CHK("start without card", 1'h0, start_allowed);
        i_plc.pulse(1'h0, 3'h4);
        settle();
        `CHK("start with card", 1'h1, start_allowed);
    endtask
    // summing input counts only with operations active
    task automatic t_ops();
        wr(`CCS_ADDR_OPS_SEL, {30'h0, `CCS_SRC_CAN});
        settle();
        rd(`CCS_ADDR_FLAGS);
        `CHK("part1 idle ops", 1'h0, f[9]);
        wr(`CCS_ADDR_OPS_SEL, 32'h0000_1000 | {30'h0, `CCS_SRC_CAN});
        settle();
        rd(`CCS_ADDR_FLAGS);
        `CHK("part1 ops", 1'h1, f[9]);
        `CHK("start blocked", 1'h0, start_allowed);
        wr(`CCS_ADDR_OPS_SEL, 32'h0000_0000);
    endtask
    // feedback only from the selected channel
    task automatic t_pid();
        wr(`CCS_ADDR_PID_SEL, {29'h0, 1'h1, `CCS_SRC_CAN});
        i_plc.send_word(`CCS_ADDR_PID_FB_W, `CCS_SRC_CAN, 16'hA5C3);
        i_plc.send_word(`CCS_ADDR_PID_FB_W, `CCS_SRC_BUS, 16'h0F0F);
        settle();
        `CHK("pid_feedback", 16'hA5C3, pid_feedback);
    endtask
    // management fault on an idle card, then mask and clear
    task automatic t_mgmt_irq();
        wr(`CCS_ADDR_DRIVE, 32'h0000_0001);
        i_plc.set_mgmt(1'h1);
        settle();
        `CHK("mgmt drive_fault", 1'h1, drive_fault);
        i_plc.set_mgmt(1'h0);
        wr(`CCS_ADDR_IRQ_MASK, 32'h0000_0000);
        settle();
        irq_a = irq;
        wr(`CCS_ADDR_IRQ_MASK, 32'h0000_000F);
        settle();
        `CHK("irq mask toggles", 1'h1, irq_a ^ irq);
        wr(`CCS_ADDR_DRIVE, 32'h0000_0001);
        wr(`CCS_ADDR_IRQ_STAT, 32'h0000_000F);
        settle();
        rd(`CCS_ADDR_IRQ_STAT);
        `CHK("irq status", 32'h0000_0000, f);
        `CHK("irq", 1'h0, irq);
    endtask

    // reset for 8 cycles, then scenarios in turn
    initial begin
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        rst = 1'h1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        t_reset();
        t_enable();
        t_react();
        t_nonpart();
        t_switch();
        t_ops();
        t_pid();
        t_mgmt_irq();
        t_card();
        results();
    end
endmodule
